// ### adc_eirq_pkg.sv
// shared constants for the early-interrupt status and input-mode register slice
package adc_eirq_pkg;
    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int NUM_CH = 32;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int CH_PER_MODE = 8;

    // ---------------------------------------------------------------
    // register offsets (word index on the plain port)
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_EARLY_IRQ_STATUS_LOW = 4'h0;
    localparam logic [3:0] OFS_EARLY_IRQ_STATUS_HIGH = 4'h1;
    localparam logic [3:0] OFS_INPUT_MODE_CH0_7 = 4'h2;
    localparam logic [3:0] OFS_INPUT_MODE_CH8_15 = 4'h3;
    localparam logic [3:0] OFS_INPUT_MODE_CH16_23 = 4'h4;
    localparam logic [3:0] OFS_EARLY_IRQ_ENABLE_LOW = 4'h5;
    localparam logic [3:0] OFS_EARLY_IRQ_ENABLE_HIGH = 4'h6;
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h7;
    localparam logic [3:0] OFS_IRQ_CLEAR = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h9;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int MODE_SIGN_POS = 0;
    localparam int MODE_SELECT_A_POS = 1;
    localparam int MODE_GROUPS = 3;
    localparam int IRQ_BITS = 2;
    localparam int IRQ_EARLY_POS = 0;
    localparam int IRQ_WRITE_ERR_POS = 1;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [31:0] RST_WIDE = 32'h0000_0000;
    localparam logic [1:0] RST_IRQ = 2'h0;
endpackage : adc_eirq_pkg

// ### chan_event_if.sv
// per-channel event wires between the register slice and its flag bank
`timescale 1ns/100ps
interface chan_event_if #(parameter int N = 32);
    logic [N-1:0] set_req;
    logic [N-1:0] clr_req;
    logic [N-1:0] flags;
    modport owner (output set_req, output clr_req, input flags);
    modport bank (input set_req, input clr_req, output flags);
endinterface : chan_event_if

// ### early_flag_bank.sv
// sticky per-channel early-interrupt flags, set wins over clear
`timescale 1ns/100ps
module early_flag_bank #(
    parameter logic [31:0] IMPL_MASK = 32'hffff_ffff
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // event wires
    chan_event_if.bank ev
);
    logic [31:0] flag_q;

    // one process owns the whole flag word, so no bit has a second driver
    // set beats clear
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flag_q <= adc_eirq_pkg::RST_WIDE;
        end else begin
            flag_q <= (ev.set_req | (flag_q & ~ev.clr_req)) & IMPL_MASK;
        end
    end

    assign ev.flags = flag_q;
endmodule : early_flag_bank

// ### adc_early_irq_status_and_input_mode.sv
// register slice: early-interrupt status, enables and per-channel input mode
`timescale 1ns/100ps
module adc_early_irq_status_and_input_mode #(
    parameter logic [31:0] IMPL_MASK = 32'hffff_ffff,
    parameter logic [31:0] SELECT_A_MASK = 32'hffff_ffff
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // converter events
    input wire logic [31:0] early_done,
    input wire logic [31:0] channel_result_buffer_rd,
    // per-channel controls toward the cores
    output logic [23:0] select_a,
    output logic [23:0] sign_select,
    output logic [31:0] early_irq_out,
    // interrupt
    output logic irq
);
    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    logic [31:0] early_irq_enable;
    logic [15:0] input_mode [adc_eirq_pkg::MODE_GROUPS];
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] early_fire;
    logic wr_err;
    logic [15:0] next_rdata;
    logic [15:0] mode_mask [adc_eirq_pkg::MODE_GROUPS];

    chan_event_if #(.N(32)) ev ();

    // mask of writable mode bits for one group of eight channels
    function automatic logic [15:0] mode_bits(input int grp);
        logic [15:0] m;
        int ch;
        m = 16'h0000;
        for (int k = 0; k < adc_eirq_pkg::CH_PER_MODE; k++) begin
            ch = grp * adc_eirq_pkg::CH_PER_MODE + k;
            m[2 * k + adc_eirq_pkg::MODE_SIGN_POS] = IMPL_MASK[ch];
            m[2 * k + adc_eirq_pkg::MODE_SELECT_A_POS] = IMPL_MASK[ch] & SELECT_A_MASK[ch];
        end
        return m;
    endfunction : mode_bits

    always_comb begin
        for (int i = 0; i < adc_eirq_pkg::MODE_GROUPS; i++) begin
            mode_mask[i] = mode_bits(i);
        end
    end

    // ---------------------------------------------------------------
    // early interrupt generation
    // ---------------------------------------------------------------
    // gated by enable
    assign early_fire = early_done & early_irq_enable & IMPL_MASK;
    assign early_irq_out = early_fire;
    assign ev.set_req = early_fire;
    assign ev.clr_req = channel_result_buffer_rd;

    early_flag_bank #(.IMPL_MASK(IMPL_MASK)) u_flags (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .ev(ev.bank)
    );

    // ---------------------------------------------------------------
    // mode outputs
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 24; g++) begin : g_mode
            assign select_a[g] = input_mode[g / 8][2 * (g % 8) + adc_eirq_pkg::MODE_SELECT_A_POS];
            assign sign_select[g] = input_mode[g / 8][2 * (g % 8) + adc_eirq_pkg::MODE_SIGN_POS];
        end
    endgenerate

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            early_irq_enable <= adc_eirq_pkg::RST_WIDE;
        end else if (reg_wr && reg_addr == adc_eirq_pkg::OFS_EARLY_IRQ_ENABLE_LOW) begin
            early_irq_enable[15:0] <= reg_wdata & IMPL_MASK[15:0];
        end else if (reg_wr && reg_addr == adc_eirq_pkg::OFS_EARLY_IRQ_ENABLE_HIGH) begin
            early_irq_enable[31:16] <= reg_wdata & IMPL_MASK[31:16];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < adc_eirq_pkg::MODE_GROUPS; i++) begin
                input_mode[i] <= adc_eirq_pkg::RST_WORD;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                adc_eirq_pkg::OFS_INPUT_MODE_CH0_7: input_mode[0] <= reg_wdata & mode_mask[0];
                adc_eirq_pkg::OFS_INPUT_MODE_CH8_15: input_mode[1] <= reg_wdata & mode_mask[1];
                adc_eirq_pkg::OFS_INPUT_MODE_CH16_23: input_mode[2] <= reg_wdata & mode_mask[2];
                default: ;
            endcase
        end
    end

    // status registers are flags driven by hardware; writes there are refused
    assign wr_err = reg_wr && (reg_addr == adc_eirq_pkg::OFS_EARLY_IRQ_STATUS_LOW
        || reg_addr == adc_eirq_pkg::OFS_EARLY_IRQ_STATUS_HIGH || reg_addr > adc_eirq_pkg::OFS_IRQ_MASK);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_mask <= adc_eirq_pkg::RST_IRQ;
        end else if (reg_wr && reg_addr == adc_eirq_pkg::OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[1:0];
        end
    end

    // ---------------------------------------------------------------
    // interrupt status: set wins over write-one-to-clear
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= adc_eirq_pkg::RST_IRQ;
        end else begin
            irq_status <= (irq_status & ~((reg_wr && reg_addr == adc_eirq_pkg::OFS_IRQ_CLEAR)
                ? reg_wdata[1:0] : 2'h0))
                | {wr_err, |early_fire};
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ---------------------------------------------------------------
    // read path, data one cycle after the strobe
    // ---------------------------------------------------------------
    always_comb begin
        case (reg_addr)
            adc_eirq_pkg::OFS_EARLY_IRQ_STATUS_LOW: next_rdata = ev.flags[15:0];
            adc_eirq_pkg::OFS_EARLY_IRQ_STATUS_HIGH: next_rdata = ev.flags[31:16];
            adc_eirq_pkg::OFS_INPUT_MODE_CH0_7: next_rdata = input_mode[0];
            adc_eirq_pkg::OFS_INPUT_MODE_CH8_15: next_rdata = input_mode[1];
            adc_eirq_pkg::OFS_INPUT_MODE_CH16_23: next_rdata = input_mode[2];
            adc_eirq_pkg::OFS_EARLY_IRQ_ENABLE_LOW: next_rdata = early_irq_enable[15:0];
            adc_eirq_pkg::OFS_EARLY_IRQ_ENABLE_HIGH: next_rdata = early_irq_enable[31:16];
            adc_eirq_pkg::OFS_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
            adc_eirq_pkg::OFS_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
            // clear register is write-only; unmapped reads zero
            default: next_rdata = adc_eirq_pkg::RST_WORD;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= adc_eirq_pkg::RST_WORD;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= adc_eirq_pkg::RST_WORD;
        end
    end
endmodule : adc_early_irq_status_and_input_mode

// ### adc_eirq_chk.sv
// assertion checker for the early-interrupt and input-mode register slice
`timescale 1ns/100ps
module adc_eirq_chk #(
    parameter logic [31:0] IMPL_MASK = 32'hffff_ffff,
    parameter logic [31:0] SELECT_A_MASK = 32'hffff_ffff
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // events and controls
    input wire logic [31:0] early_done,
    input wire logic [31:0] channel_result_buffer_rd,
    input wire logic [23:0] select_a,
    input wire logic [23:0] sign_select,
    input wire logic [31:0] early_irq_out,
    input wire logic irq
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data not zero outside a read answer");
    early_gate_a: assert property ((early_irq_out & ~early_done) == 32'h0)
        else $error("early interrupt without event");
    absent_zero_a: assert property ((early_irq_out & ~IMPL_MASK) == 32'h0 && (sign_select & ~IMPL_MASK[23:0]) == 24'h0)
        else $error("absent channel active");
    select_a_capable_a: assert property ((select_a & ~SELECT_A_MASK[23:0]) == 24'h0)
        else $error("differential select on incapable channel");
    mode_hold_a: assert property (!reg_wr |=> $stable(select_a) && $stable(sign_select))
        else $error("mode changed without a write");
    mode_layout_a: assert property (reg_wr && reg_addr == 4'h2 |=>
        sign_select[1] == $past(reg_wdata[2]) && select_a[1] == $past(reg_wdata[3]))
        else $error("mode bit layout wrong");
    high_flag_a: assert property (early_irq_out[17] ##2 (reg_rd && reg_addr == 4'h1) |=> reg_rdata[1])
        else $error("channel 17 flag not in high status");
    set_wins_a: assert property (early_irq_out[2] && channel_result_buffer_rd[2]
        ##1 !channel_result_buffer_rd[2] ##1 (reg_rd && reg_addr == 4'h0 && !channel_result_buffer_rd[2]) |=> reg_rdata[2])
        else $error("simultaneous clear lost the event");
    read_clears_a: assert property (channel_result_buffer_rd[1] && !early_irq_out[1]
        ##1 !early_irq_out[1] ##1 (reg_rd && reg_addr == 4'h0) |=> !reg_rdata[1])
        else $error("buffer read did not clear flag");
endmodule : adc_eirq_chk

bind adc_early_irq_status_and_input_mode adc_eirq_chk #(.IMPL_MASK(IMPL_MASK), .SELECT_A_MASK(SELECT_A_MASK)) chk_i (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .early_done(early_done),
    .channel_result_buffer_rd(channel_result_buffer_rd), .select_a(select_a), .sign_select(sign_select),
    .early_irq_out(early_irq_out), .irq(irq));

// ### testbench.sv
// self-checking testbench for the early-interrupt and input-mode register slice
`timescale 1ns/100ps
module testbench;
    typedef struct packed {logic [3:0] a; logic [15:0] d; logic [15:0] q;} row_t;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0;
    logic [31:0] early_done = 32'h0;
    logic [31:0] channel_result_buffer_rd = 32'h0;
    logic [15:0] reg_rdata;
    logic [31:0] early_irq_out;
    logic [23:0] select_a, sign_select;
    logic irq;
    int failures = 0;
    int check_count = 0;
    // channel 31 absent, channel 0 single-ended only
    row_t rows [8] = '{'{4'h2, 16'hffff, 16'hfffd}, '{4'h3, 16'haaaa, 16'haaaa}, '{4'h4, 16'h5555, 16'h5555},
        '{4'h5, 16'hffff, 16'hffff}, '{4'h6, 16'hffff, 16'h7fff}, '{4'h0, 16'hffff, 16'h0000},
        '{4'hc, 16'hffff, 16'h0000}, '{4'h9, 16'h0003, 16'h0003}};
    adc_early_irq_status_and_input_mode #(.IMPL_MASK(32'h7fff_ffff), .SELECT_A_MASK(32'hffff_fffe)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .early_done(early_done),
        .channel_result_buffer_rd(channel_result_buffer_rd), .select_a(select_a), .sign_select(sign_select),
        .early_irq_out(early_irq_out), .irq(irq));
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        if (failures == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // gap cycle after each strobe so no strobe is assigned twice in one step
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [15:0] q);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("rdata %h", a), {16'h0, reg_rdata}, {16'h0, q});
        @(posedge sys_clk);
    endtask : rd
    task automatic pulse(input logic [31:0] ev, input logic [31:0] br, input logic [31:0] q);
        early_done <= ev;
        channel_result_buffer_rd <= br;
        #1;
        chk("early_irq_out", early_irq_out, q);
        @(posedge sys_clk);
        early_done <= 32'h0;
        channel_result_buffer_rd <= 32'h0;
        @(posedge sys_clk);
    endtask : pulse
    task automatic irq_is(input logic e);
        #1;
        chk("irq", {31'h0, irq}, {31'h0, e});
        @(posedge sys_clk);
    endtask : irq_is
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    initial begin
        #100000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 10; a++) begin
            rd(a[3:0], 16'h0);
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].q);
        end
        chk("select_a", {8'h0, select_a}, 32'h00fffe);
        chk("sign_select", {8'h0, sign_select}, 32'hff00ff);
        irq_is(1'b1);
        rd(4'h7, 16'h2);
        wr(4'h8, 16'h2);
        rd(4'h7, 16'h0);
        irq_is(1'b0);
        pulse(32'h8002_0002, 32'h0, 32'h0002_0002);
        rd(4'h1, 16'h2);
        rd(4'h0, 16'h2);
        irq_is(1'b1);
        wr(4'h9, 16'h2);
        irq_is(1'b0);
        wr(4'h8, 16'h1);
        wr(4'h9, 16'h3);
        wr(4'h5, 16'h0);
        pulse(32'h4, 32'h0, 32'h0);
        rd(4'h0, 16'h2);
        wr(4'h5, 16'hffff);
        pulse(32'h4, 32'h6, 32'h4);
        rd(4'h0, 16'h4);
        pulse(32'h0, 32'h2_0000, 32'h0);
        rd(4'h1, 16'h0);
        // status event and clear write in one cycle: the event must survive
        early_done <= 32'h4;
        reg_addr <= 4'h8;
        reg_wdata <= 16'h1;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        early_done <= 32'h0;
        reg_wr <= 1'b0;
        @(posedge sys_clk);
        rd(4'h7, 16'h1);
        wr(4'h8, 16'h1);
        rd(4'h7, 16'h0);
        sys_rst <= 1'b1;
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(4'h2, 16'h0);
        chk("select_a", {8'h0, select_a}, 32'h0);
        end_of_test();
    end
endmodule : testbench
